// ===== design/audio_port_hpf_and_volume.sv
// audio port one: record high-pass filter and playback volume with shared update
// assumes register port and sample strobes come from logic on i_clk
//
// How it works
// - left and right record filters enable separately, bits 12 and 11; 0 bypasses.
// - bits 14:13 pick the corner: 00 hi-fi, 01..11 voice modes one to three.
// - hi-fi corner sits near 3.6 Hz at 44.1 kHz, 4 Hz at 48 kHz.
// - at 8 kHz the voice corners are about 64, 130 and 267 Hz.
// - fixed per-mode coefficients run at the sample rate, so corners scale with it.
// - after reset the corner field reads 00 and both filter enables read 0.
// - code X attenuates 0.375 dB times (192-X) below 192, 00h mutes; 192 and above 0 dB.
// - each channel has its own code in bits 7:0, reset to C0h.
// - a write with update bit 0 stores the code, applied gain unchanged.
// - writing 1 to bit 8 of either register applies both codes together.
// - the update bit is a write-only strobe in both gain registers.
`timescale 1ns/1ps
module audio_port_hpf_and_volume
  import audio_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // record path
  input wire logic i_rec_valid,
  input wire logic signed [SAMPLE_W-1:0] i_rec_left,
  input wire logic signed [SAMPLE_W-1:0] i_rec_right,
  output logic o_rec_valid,
  output logic signed [SAMPLE_W-1:0] o_rec_left,
  output logic signed [SAMPLE_W-1:0] o_rec_right,
  // playback path
  input wire logic i_play_valid,
  input wire logic signed [SAMPLE_W-1:0] i_play_left,
  input wire logic signed [SAMPLE_W-1:0] i_play_right,
  output logic o_play_valid,
  output logic signed [SAMPLE_W-1:0] o_play_left,
  output logic signed [SAMPLE_W-1:0] o_play_right
);

  // ==========================================================================
  // reset release
  logic rst_meta_reg;
  logic rst_n_reg;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ==========================================================================
  // address decode
  wire sel_left = (i_addr == ADDR_PLAY_LEFT);
  wire sel_right = (i_addr == ADDR_PLAY_RIGHT);
  wire sel_filter = (i_addr == ADDR_REC_FILTER);
  wire sel_status = (i_addr == ADDR_GAIN_STATUS);
  wire wr_left = i_wr && sel_left;
  wire wr_right = i_wr && sel_right;
  wire wr_filter = i_wr && sel_filter;
  wire update_req = (wr_left || wr_right) && i_wdata[GAIN_UPDATE_BIT];

  // ==========================================================================
  // control registers
  logic [7:0] left_code_reg;
  logic [7:0] right_code_reg;
  logic [7:0] left_applied_reg;
  logic [7:0] right_applied_reg;
  logic pending_reg;
  logic pending_next;
  corner_t corner_reg;
  logic hpf_left_en_reg;
  logic hpf_right_en_reg;

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      left_code_reg <= GAIN_CODE_RESET;
      right_code_reg <= GAIN_CODE_RESET;
    end else begin
      if (wr_left) begin
        left_code_reg <= i_wdata[GAIN_CODE_LSB +: GAIN_CODE_W];
      end
      if (wr_right) begin
        right_code_reg <= i_wdata[GAIN_CODE_LSB +: GAIN_CODE_W];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      corner_reg <= corner_t'(HPF_SEL_RESET);
      hpf_left_en_reg <= HPF_EN_RESET;
      hpf_right_en_reg <= HPF_EN_RESET;
    end else if (wr_filter) begin
      corner_reg <= corner_t'(i_wdata[HPF_SEL_MSB:HPF_SEL_LSB]);
      hpf_left_en_reg <= i_wdata[HPF_LEFT_EN_BIT];
      hpf_right_en_reg <= i_wdata[HPF_RIGHT_EN_BIT];
    end
  end

  // ==========================================================================
  // simultaneous gain transfer at a sample boundary
  // a request in the same cycle as the transfer stays pending for the next sample
  wire apply_now = pending_reg && i_play_valid;

  always_comb begin
    pending_next = pending_reg;
    if (apply_now) begin
      pending_next = 1'b0;
    end
    if (update_req) begin
      pending_next = 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      pending_reg <= 1'b0;
      left_applied_reg <= GAIN_CODE_RESET;
      right_applied_reg <= GAIN_CODE_RESET;
    end else begin
      pending_reg <= pending_next;
      if (apply_now) begin
        left_applied_reg <= left_code_reg;
        right_applied_reg <= right_code_reg;
      end
    end
  end

  // ==========================================================================
  // playback gain stage; samples taken with a pending transfer use the new pair
  wire [7:0] left_gain_use = apply_now ? left_code_reg : left_applied_reg;
  wire [7:0] right_gain_use = apply_now ? right_code_reg : right_applied_reg;
  logic play_valid_reg;
  sample_t play_left_reg;
  sample_t play_right_reg;

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      play_valid_reg <= 1'b0;
      play_left_reg <= '0;
      play_right_reg <= '0;
    end else begin
      play_valid_reg <= i_play_valid;
      if (i_play_valid) begin
        play_left_reg <= gain_apply(i_play_left, left_gain_use);
        play_right_reg <= gain_apply(i_play_right, right_gain_use);
      end
    end
  end

  assign o_play_valid = play_valid_reg;
  assign o_play_left = play_left_reg;
  assign o_play_right = play_right_reg;

  // ==========================================================================
  // record filter
  hpf_link_if link ();

  assign link.rst_n = rst_n_reg;
  assign link.corner_sel = corner_reg;
  assign link.left_en = hpf_left_en_reg;
  assign link.right_en = hpf_right_en_reg;
  assign link.in_valid = i_rec_valid;
  assign link.in_left = i_rec_left;
  assign link.in_right = i_rec_right;

  record_hpf u_record_hpf (
    .i_clk (i_clk),
    .link (link.filt)
  );

  assign o_rec_valid = link.out_valid;
  assign o_rec_left = link.out_left;
  assign o_rec_right = link.out_right;

  // ==========================================================================
  // read back; update bit always reads zero
  wire [15:0] left_view = {8'h00, left_code_reg};
  wire [15:0] right_view = {8'h00, right_code_reg};
  wire [15:0] filter_view = {1'b0, corner_reg, hpf_left_en_reg, hpf_right_en_reg, 11'h000};
  wire [15:0] status_view = {right_applied_reg, left_applied_reg};
  wire [15:0] read_mux = sel_left ? left_view :
                         sel_right ? right_view :
                         sel_filter ? filter_view :
                         sel_status ? status_view :
                         16'h0000;
  logic [15:0] rdata_reg;

  always_ff @(posedge i_clk or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      rdata_reg <= 16'h0000;
    end else if (i_rd) begin
      rdata_reg <= read_mux;
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  assign o_rdata = rdata_reg;

endmodule : audio_port_hpf_and_volume

// ===== design/audio_port_pkg.sv
// constants, types and shared arithmetic for the port one record filter and playback gain
// assumes a single 250 MHz clock; sample strobes come from logic on that clock
package audio_port_pkg;

  // ==========================================================================
  // register map
  localparam logic [15:0] ADDR_PLAY_LEFT = 16'h0402;
  localparam logic [15:0] ADDR_PLAY_RIGHT = 16'h0403;
  localparam logic [15:0] ADDR_REC_FILTER = 16'h0410;
  localparam logic [15:0] ADDR_GAIN_STATUS = 16'h0411;

  // ==========================================================================
  // field positions
  localparam int GAIN_CODE_LSB = 0;
  localparam int GAIN_CODE_W = 8;
  localparam int GAIN_UPDATE_BIT = 8;
  localparam int STATUS_PENDING_BIT = 0;
  localparam int HPF_RIGHT_EN_BIT = 11;
  localparam int HPF_LEFT_EN_BIT = 12;
  localparam int HPF_SEL_LSB = 13;
  localparam int HPF_SEL_MSB = 14;

  // ==========================================================================
  // reset values
  localparam logic [7:0] GAIN_CODE_RESET = 8'hC0;
  localparam logic [1:0] HPF_SEL_RESET = 2'h0;
  localparam logic HPF_EN_RESET = 1'b0;

  // ==========================================================================
  // data path sizes and constants
  localparam int SAMPLE_W = 24;
  localparam int FRAC_W = 15;
  localparam int ACC_W = SAMPLE_W + FRAC_W + 2;
  localparam logic [7:0] GAIN_UNITY_CODE = 8'hC0;
  localparam logic [7:0] GAIN_MUTE_CODE = 8'h00;

  typedef logic signed [SAMPLE_W-1:0] sample_t;
  typedef logic signed [ACC_W-1:0] acc_t;
  typedef enum logic [1:0] {CORNER_HIFI, CORNER_VOICE1, CORNER_VOICE2, CORNER_VOICE3} corner_t;

  // ==========================================================================
  // leak coefficient per corner, Q15: 2*pi*fc/fs, fixed so fc tracks fs
  function automatic logic [15:0] hpf_leak(input corner_t sel);
    unique case (sel)
      CORNER_HIFI: hpf_leak = 16'h0011;
      CORNER_VOICE1: hpf_leak = 16'h066F;
      CORNER_VOICE2: hpf_leak = 16'h0D12;
      CORNER_VOICE3: hpf_leak = 16'h1AD7;
    endcase
  endfunction : hpf_leak

  // clamp a wide value to the sample range
  function automatic sample_t clamp(input acc_t v);
    if (v > acc_t'({1'b0, {(SAMPLE_W-1){1'b1}}})) begin
      clamp = {1'b0, {(SAMPLE_W-1){1'b1}}};
    end else if (v < -acc_t'({1'b0, {(SAMPLE_W-1){1'b1}}}) - acc_t'(1)) begin
      clamp = {1'b1, {(SAMPLE_W-1){1'b0}}};
    end else begin
      clamp = v[SAMPLE_W-1:0];
    end
  endfunction : clamp

  // Q15 mantissa for 0.375 dB steps within one 6 dB octave
  function automatic logic [16:0] gain_mant(input logic [3:0] k);
    unique case (k)
      4'h0: gain_mant = 17'h08000;
      4'h1: gain_mant = 17'h07A98;
      4'h2: gain_mant = 17'h0756A;
      4'h3: gain_mant = 17'h07074;
      4'h4: gain_mant = 17'h06BB3;
      4'h5: gain_mant = 17'h06726;
      4'h6: gain_mant = 17'h062CA;
      4'h7: gain_mant = 17'h05E9D;
      4'h8: gain_mant = 17'h05A9E;
      4'h9: gain_mant = 17'h056CA;
      4'hA: gain_mant = 17'h0531F;
      4'hB: gain_mant = 17'h04F9C;
      4'hC: gain_mant = 17'h04C3F;
      4'hD: gain_mant = 17'h04906;
      4'hE: gain_mant = 17'h045F0;
      4'hF: gain_mant = 17'h042FC;
    endcase
  endfunction : gain_mant

  // scale one sample by an eight-bit attenuation code
  function automatic sample_t gain_apply(input sample_t s, input logic [7:0] code);
    logic [7:0] steps;
    logic signed [SAMPLE_W+17:0] prod;
    steps = 8'h00;
    prod = '0;
    if (code == GAIN_MUTE_CODE) begin
      gain_apply = '0;
    end else if (code >= GAIN_UNITY_CODE) begin
      gain_apply = s;
    end else begin
      steps = GAIN_UNITY_CODE - code;
      prod = (SAMPLE_W+18)'(s) * $signed({1'b0, gain_mant(steps[3:0])});
      prod = prod >>> FRAC_W;
      prod = prod >>> steps[7:4];
      gain_apply = prod[SAMPLE_W-1:0];
    end
  endfunction : gain_apply

endpackage : audio_port_pkg

// ===== design/hpf_link_if.sv
// control and sample bundle between the top and the record filter
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface hpf_link_if;
  import audio_port_pkg::*;
  logic rst_n;
  corner_t corner_sel;
  logic left_en;
  logic right_en;
  logic in_valid;
  sample_t in_left;
  sample_t in_right;
  logic out_valid;
  sample_t out_left;
  sample_t out_right;
  modport ctl (output rst_n, corner_sel, left_en, right_en, in_valid, in_left, in_right,
               input out_valid, out_left, out_right);
  modport filt (input rst_n, corner_sel, left_en, right_en, in_valid, in_left, in_right,
                output out_valid, out_left, out_right);
endinterface : hpf_link_if

// ===== design/record_hpf.sv
// two-channel dc-removing first order high-pass filter for the record path
// assumes one sample pair per in_valid pulse, from logic on the same clock
`timescale 1ns/1ps
module record_hpf
  import audio_port_pkg::*;
(
  // clock
  input wire logic i_clk,
  // link to the top
  hpf_link_if.filt link
);

  // ==========================================================================
  // per-channel filter step
  acc_t acc_reg [2];
  sample_t prev_reg [2];
  sample_t in_s [2];
  logic en_s [2];
  acc_t acc_next [2];
  sample_t y_next [2];
  logic [15:0] leak;
  sample_t out_left_reg;
  sample_t out_right_reg;
  logic out_valid_reg;

  assign in_s[0] = link.in_left;
  assign in_s[1] = link.in_right;
  assign en_s[0] = link.left_en;
  assign en_s[1] = link.right_en;
  assign leak = hpf_leak(link.corner_sel);

  always_comb begin
    for (int c = 0; c < 2; c++) begin
      acc_t diff;
      logic signed [ACC_W+16:0] decay;
      diff = (acc_t'(in_s[c]) - acc_t'(prev_reg[c])) <<< FRAC_W;
      decay = (ACC_W+17)'(acc_reg[c]) * $signed({1'b0, leak});
      acc_next[c] = acc_reg[c] + diff - acc_t'(decay >>> FRAC_W);
      y_next[c] = en_s[c] ? clamp(acc_next[c] >>> FRAC_W) : in_s[c];
    end
  end

  // ==========================================================================
  // state and outputs
  always_ff @(posedge i_clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      for (int c = 0; c < 2; c++) begin
        acc_reg[c] <= '0;
        prev_reg[c] <= '0;
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (!en_s[c]) begin
          acc_reg[c] <= '0;
          prev_reg[c] <= '0;
        end else if (link.in_valid) begin
          acc_reg[c] <= acc_next[c];
          prev_reg[c] <= in_s[c];
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge link.rst_n) begin
    if (!link.rst_n) begin
      out_valid_reg <= 1'b0;
      out_left_reg <= '0;
      out_right_reg <= '0;
    end else begin
      out_valid_reg <= link.in_valid;
      if (link.in_valid) begin
        out_left_reg <= y_next[0];
        out_right_reg <= y_next[1];
      end
    end
  end

  assign link.out_valid = out_valid_reg;
  assign link.out_left = out_left_reg;
  assign link.out_right = out_right_reg;

endmodule : record_hpf

// ===== verif/audio_port_props.sv
// checker for the port one record filter and playback gain block
// assumes it sees only the top module ports, bound below
`timescale 1ns/1ps
module audio_port_props
  import audio_port_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset_n,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [15:0] o_rdata,
  // sample paths
  input wire logic i_rec_valid,
  input wire logic o_rec_valid,
  input wire logic signed [SAMPLE_W-1:0] o_rec_left,
  input wire logic i_play_valid,
  input wire logic o_play_valid,
  input wire logic signed [SAMPLE_W-1:0] o_play_left
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  wire logic gain_addr = (i_addr == ADDR_PLAY_LEFT) || (i_addr == ADDR_PLAY_RIGHT);
  wire logic mapped = gain_addr || (i_addr == ADDR_REC_FILTER) || (i_addr == ADDR_GAIN_STATUS);
  // ==========================================================================
  // assertions
  chk_rec_answer: assert property (
    i_rec_valid |=> o_rec_valid) else $error("record output late");
  chk_rec_single: assert property (
    o_rec_valid |-> $past(i_rec_valid)) else $error("record output without input");
  chk_rec_hold: assert property (
    !o_rec_valid |-> $stable(o_rec_left)) else $error("record data moved between samples");
  chk_play_answer: assert property (
    i_play_valid |=> o_play_valid) else $error("playback output late");
  chk_play_single: assert property (
    !i_play_valid |=> !o_play_valid) else $error("playback output without input");
  chk_play_hold: assert property (
    !o_play_valid |-> $stable(o_play_left)) else $error("playback data moved between samples");
  chk_rdata_idle: assert property (
    !i_rd |=> o_rdata == 16'h0000) else $error("read data outside read slot");
  chk_update_reads_zero: assert property (
    i_rd && gain_addr |=> !o_rdata[GAIN_UPDATE_BIT]) else $error("update bit read back");
  chk_unmapped_zero: assert property (
    i_rd && !mapped |=> o_rdata == 16'h0000) else $error("unmapped read not zero");
  chk_filter_spare: assert property (
    i_rd && i_addr == ADDR_REC_FILTER |=> o_rdata[15] == 1'b0 && o_rdata[10:0] == 11'h000)
    else $error("filter register spare bits set");
  cov_update: cover property (i_wr && gain_addr);
  cov_rec: cover property (i_rec_valid ##1 o_rec_valid);
  cov_status: cover property (i_rd && i_addr == ADDR_GAIN_STATUS);
endmodule : audio_port_props

bind audio_port_hpf_and_volume audio_port_props u_props (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_addr(i_addr),
  .i_wr(i_wr),
  .i_rd(i_rd),
  .o_rdata(o_rdata),
  .i_rec_valid(i_rec_valid),
  .o_rec_valid(o_rec_valid),
  .o_rec_left(o_rec_left),
  .i_play_valid(i_play_valid),
  .o_play_valid(o_play_valid),
  .o_play_left(o_play_left)
);

// ===== verif/audio_far_side.sv
// far side model: serial port and mixing core sending sample pairs
// assumes requests change just after a rising edge of i_clk
`timescale 1ns/1ps
module audio_far_side
  import audio_port_pkg::*;
(
  // clock
  input wire logic i_clk,
  // record samples
  output logic o_rec_valid,
  output sample_t o_rec_left,
  output sample_t o_rec_right,
  // playback samples
  output logic o_play_valid,
  output sample_t o_play_left,
  output sample_t o_play_right
);
  initial begin
    o_rec_valid = 1'b0;
    o_rec_left = '0;
    o_rec_right = '0;
    o_play_valid = 1'b0;
    o_play_left = '0;
    o_play_right = '0;
  end
  // one record pair after gap idle cycles; data inverted once released
  task automatic send_rec(input sample_t l, input sample_t r, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_rec_valid <= 1'b1;
    o_rec_left <= l;
    o_rec_right <= r;
    @(posedge i_clk);
    o_rec_valid <= 1'b0;
    o_rec_left <= ~l;
    o_rec_right <= ~r;
  endtask : send_rec
  task automatic send_play(input sample_t l, input sample_t r, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_play_valid <= 1'b1;
    o_play_left <= l;
    o_play_right <= r;
    @(posedge i_clk);
    o_play_valid <= 1'b0;
    o_play_left <= ~l;
    o_play_right <= ~r;
  endtask : send_play
endmodule : audio_far_side

// ===== verif/tb_top.sv
// self-checking bench for the port one record filter and playback gain block
// assumes the far side model drives the sample strobes
`timescale 1ns/1ps
module tb_top;
  import audio_port_pkg::*;
  logic i_clk;
  logic i_reset_n;
  logic [15:0] i_addr;
  logic [15:0] i_wdata;
  logic i_wr;
  logic i_rd;
  logic [15:0] o_rdata;
  logic rec_v, play_v, o_rec_valid, o_play_valid;
  sample_t rec_l, rec_r, play_l, play_r, o_rec_left, o_rec_right, o_play_left, o_play_right;
  sample_t x;
  sample_t y;
  int n_fail;
  int comparisons;
  int cycles = 0;
  logic [15:0] leak [4] = '{16'h0011, 16'h066F, 16'h0D12, 16'h1AD7};

  audio_port_hpf_and_volume dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rec_valid(rec_v), .i_rec_left(rec_l), .i_rec_right(rec_r),
    .o_rec_valid(o_rec_valid), .o_rec_left(o_rec_left), .o_rec_right(o_rec_right),
    .i_play_valid(play_v), .i_play_left(play_l), .i_play_right(play_r),
    .o_play_valid(o_play_valid), .o_play_left(o_play_left), .o_play_right(o_play_right));
  audio_far_side far (.i_clk(i_clk), .o_rec_valid(rec_v), .o_rec_left(rec_l),
    .o_rec_right(rec_r), .o_play_valid(play_v), .o_play_left(play_l), .o_play_right(play_r));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  // ==========================================================================
  // shared tasks
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check("rdata", {8'h00, exp}, {8'h00, o_rdata});
  endtask : reg_rd
  task automatic rec_pair(input sample_t l, input sample_t r, input sample_t el,
                          input sample_t er);
    far.send_rec(l, r, 0);
    @(negedge i_clk);
    check("rec valid", 24'h000001, {23'h0, o_rec_valid});
    check("rec left", el, o_rec_left);
    check("rec right", er, o_rec_right);
  endtask : rec_pair
  task automatic play_pair(input sample_t l, input sample_t r, input sample_t el,
                           input sample_t er);
    far.send_play(l, r, 2);
    @(negedge i_clk);
    check("play valid", 24'h000001, {23'h0, o_play_valid});
    check("play left", el, o_play_left);
    check("play right", er, o_play_right);
  endtask : play_pair
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test
  // ==========================================================================
  // timeout
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      finish_test();
    end
  end
  // ==========================================================================
  // tests
  initial begin
    i_reset_n = 1'b0;
    i_addr = 16'h0000;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    n_fail = 0;
    comparisons = 0;
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    reg_rd(ADDR_PLAY_LEFT, 16'h00C0);
    reg_rd(ADDR_PLAY_RIGHT, 16'h00C0);
    reg_rd(ADDR_REC_FILTER, 16'h0000);
    reg_rd(ADDR_GAIN_STATUS, 16'hC0C0);
    reg_rd(16'h0404, 16'h0000);
    reg_wr(ADDR_REC_FILTER, 16'hFFFF);
    reg_rd(ADDR_REC_FILTER, 16'h7800);
    // stored codes wait for the update strobe
    reg_wr(ADDR_PLAY_LEFT, 16'h00B0);
    reg_wr(ADDR_PLAY_RIGHT, 16'h00A0);
    reg_rd(ADDR_PLAY_LEFT, 16'h00B0);
    play_pair(24'h100000, 24'h100000, 24'h100000, 24'h100000);
    reg_rd(ADDR_GAIN_STATUS, 16'hC0C0);
    reg_wr(ADDR_PLAY_RIGHT, 16'h01A0);
    reg_rd(ADDR_PLAY_RIGHT, 16'h00A0);
    play_pair(24'h100000, 24'hF00000, 24'h080000, 24'hFC0000);
    reg_rd(ADDR_GAIN_STATUS, 16'hA0B0);
    // mute and top code, update through the left register
    reg_wr(ADDR_PLAY_RIGHT, 16'h00FF);
    reg_wr(ADDR_PLAY_LEFT, 16'h0100);
    play_pair(24'h123456, 24'h123456, 24'h000000, 24'h123456);
    reg_rd(ADDR_GAIN_STATUS, 16'hFF00);
    // every corner, voice ones as software would pick them
    x = 24'h010000;
    for (int k = 0; k < 4; k++) begin
      reg_wr(ADDR_REC_FILTER, 16'h0000);
      reg_wr(ADDR_REC_FILTER, {1'b0, k[1:0], ~k[0], k[0], 11'h000});
      rec_pair(x, x, x, x);
      y = x - {7'h00, leak[k], 1'b0};
      if (k[0]) begin
        rec_pair(x, x, x, y);
      end else begin
        rec_pair(x, x, y, x);
      end
    end
    finish_test();
  end
endmodule : tb_top
